// ---- include/flrl_defs.vh ----
// constants for the flash region lock register block
`ifndef FLRL_DEFS_VH
`define FLRL_DEFS_VH

// opcodes
`define FLRL_OP_LS_RD       8'hA7
`define FLRL_OP_GUARD_LATCH 8'hA6
`define FLRL_OP_RD_ANY      8'h65
`define FLRL_OP_WR_ANY      8'h71
`define FLRL_OP_BL_RD       8'h3D
`define FLRL_OP_BL_RD_W     8'hE0
`define FLRL_OP_BL_LOCK     8'h36
`define FLRL_OP_BL_LOCK_W   8'hE1
`define FLRL_OP_BL_UNL      8'h39
`define FLRL_OP_BL_UNL_W    8'hE2
`define FLRL_OP_GBL         8'h7E
`define FLRL_OP_GLOBAL_BLOCK_UNLOCK_CMD        8'h98
`define FLRL_OP_SPG         8'hFB
`define FLRL_OP_SPG_W       8'hE3

// lock status register layout
`define FLRL_LS_NV_CONFIG_LOCK_BIT  0
`define FLRL_LS_R3PW_BIT    6
`define FLRL_LS_RESV        5'h00

// block lock access register values
`define FLRL_BL_PROT        8'h00
`define FLRL_BL_OPEN        8'hFF

// pointer guard register layout and default
`define FLRL_PG_RESET       32'hFFFFFFFF
`define FLRL_PG_ALL_BIT     11
`define FLRL_PG_EN_BIT      10
`define FLRL_PG_DIR_BIT     9
`define FLRL_PG_A24_BIT     24
`define FLRL_PG_ADDR_HI     24
`define FLRL_PG_ADDR_LO     12

// any-register addresses
`define FLRL_RA_LOCK_STATUS 32'h00000030
`define FLRL_RA_POINTER     32'h00000040

// address handling
`define FLRL_SHORT_MASK     32'h00FFFFFF
`define FLRL_BLK_SHIFT      16

// start-up sequencing of the caught mode bits
`define FLRL_INIT_LOAD      2'h2
`define FLRL_INIT_DONE      2'h3

`endif

// ---- core/flrl_sync.v ----
// two flip-flop synchroniser for level inputs
`timescale 1ns/1ps

module flrl_sync #(
   parameter W = 1
) (
   // clock and reset
   input  wire         clk,
   input  wire         arst_n,
   // levels
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;

endmodule

// ---- core/flrl_lock_regs.v ----
// lock status, block lock array and pointer guard logic of the flash
`timescale 1ns/1ps
`include "flrl_defs.vh"

// Notes on behaviour
// RULE1 - lock status is volatile read-only, returned by status read or read-any.
// RULE2 - while config lock bit is 0, region and pointer guard changes are refused; the code refuses only pointer guard writes, block lock opcodes still run.
// RULE3 - status bit 0 is write permission; reset value from two mode bits.
// RULE4 - the guard latch opcode sets the config lock bit to 1.
// RULE5 - status bit 6 mirrors the region-3 read password mode bit.
// RULE6 - status bits 5 to 1 always read as zero.
// RULE7 - block lock access value is 00h when protected, FFh when open.
// RULE8 - block lock state is volatile only, no non-volatile copy.
// RULE9 - per-block lock opcodes protect one block, global lock protects all.
// RULE10 - per-block unlock opcodes open one block, global unlock opens all.
// RULE11 - block lock read opcodes return the addressed block's lock state.
// RULE12 - pointer guard is written by set-pointer opcodes or write-any.
// RULE13 - pointer address sits in A24 and A23 to A12; A24 reserved if small.
// RULE14 - field A11 zero guards pointer region only, one guards all sectors.
// RULE15 - field A10 zero enables pointer region guarding, one disables it.
// RULE16 - field A9 zero starts region at top, one at bottom.
// RULE17 - every pointer guard bit defaults to one.
// RULE18 - boot default bit one brings all blocks up locked after any reset.
// RULE19 - write-any aimed at lock status leaves it unchanged.
// RULE20 - program or erase aimed at a protected block is rejected.
module flrl_lock_regs #(
   parameter NUM_BLOCKS = 512,
   parameter BLK_AW     = 9,
   parameter LARGE_DENS = 1
) (
   // clock and reset
   input  wire        clk,
   input  wire        arst_n,
   // decoded command from the serial front end
   input  wire        cmd_valid,
   input  wire [7:0]  cmd_opcode,
   input  wire [31:0] cmd_addr,
   input  wire [31:0] cmd_wdata,
   input  wire        write_enable_latch,
   input  wire        soft_reset,
   // one-time mode bits, arriving as pins
   input  wire        region3_read_password,
   input  wire        guard_mode_otp_pwd,
   input  wire        guard_mode_otp_perm,
   input  wire        block_lock_boot_default,
   // program and erase gate
   input  wire        pe_req,
   input  wire [31:0] pe_addr,
   // answers
   output reg         rsp_valid,
   output reg  [31:0] rsp_data,
   output reg         cmd_refused,
   output reg         nv_config_lock,
   output reg  [31:0] pointer_guard_reg,
   output reg         pe_grant,
   output reg         pe_reject
);

   ////////////////////////////////////////////////////////////////////////////
   // mode bit synchronisers

   wire [3:0] otp_sync;

   flrl_sync #(
      .W (4)
   ) u_otp_sync (
      .clk    (clk),
      .arst_n (arst_n),
      .d      ({block_lock_boot_default, guard_mode_otp_perm,
                guard_mode_otp_pwd, region3_read_password}),
      .q      (otp_sync)
   );

   wire r3pw_s  = otp_sync[0];
   wire pwd_s   = otp_sync[1];
   wire perm_s  = otp_sync[2];
   wire boot_s  = otp_sync[3];

   ////////////////////////////////////////////////////////////////////////////
   // state

   reg  [1:0]            init_q;
   reg  [NUM_BLOCKS-1:0] blk_open_q;
   reg  [NUM_BLOCKS-1:0] blk_open_d;
   reg                   nv_config_lock_d;
   reg  [31:0]           ptr_d;
   reg                   rsp_valid_d;
   reg  [31:0]           rsp_data_d;
   reg                   refused_d;

   wire ready = (init_q == `FLRL_INIT_DONE);

   // mode bits only settle two edges after release, so load waits for them
   wire load_boot = (init_q == `FLRL_INIT_LOAD) | (ready & soft_reset);

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   wire wide_op = (cmd_opcode == `FLRL_OP_BL_RD_W) |
                  (cmd_opcode == `FLRL_OP_BL_LOCK_W) |
                  (cmd_opcode == `FLRL_OP_BL_UNL_W) |
                  (cmd_opcode == `FLRL_OP_SPG_W);

   // short forms carry three address bytes only
   wire [31:0] eff_addr = wide_op ? cmd_addr : (cmd_addr & `FLRL_SHORT_MASK);

   wire [BLK_AW-1:0] cmd_blk = eff_addr[`FLRL_BLK_SHIFT +: BLK_AW];
   wire [BLK_AW-1:0] pe_blk  = pe_addr[`FLRL_BLK_SHIFT +: BLK_AW];

   // status byte: reserved field fixed at zero, no storage behind it
   wire [7:0] lock_status_reg = {1'b0, r3pw_s, `FLRL_LS_RESV, nv_config_lock}; // RULE1 RULE5 RULE6

   wire pg_write_ok = nv_config_lock & write_enable_latch; // RULE2

   // small density has no A24, keep it at its reserved one
   wire [31:0] ptr_wval = (LARGE_DENS != 0) ? cmd_wdata :
                          (cmd_wdata | (32'h00000001 << `FLRL_PG_A24_BIT)); // RULE13

   ////////////////////////////////////////////////////////////////////////////
   // command execution

   always @* begin
      blk_open_d  = blk_open_q;
      nv_config_lock_d    = nv_config_lock;
      ptr_d       = pointer_guard_reg;
      rsp_valid_d = 1'b0;
      rsp_data_d  = 32'h00000000;
      refused_d   = 1'b0;
      if (load_boot) begin
         blk_open_d = boot_s ? {NUM_BLOCKS{1'b0}} : {NUM_BLOCKS{1'b1}}; // RULE18 RULE8
         nv_config_lock_d   = pwd_s & perm_s; // RULE3
      end else if (cmd_valid & ready) begin
         case (cmd_opcode)
            `FLRL_OP_LS_RD: begin
               rsp_valid_d = 1'b1;
               rsp_data_d  = {24'h000000, lock_status_reg}; // RULE1
            end
            `FLRL_OP_GUARD_LATCH: begin
               nv_config_lock_d = 1'b1; // RULE4
            end
            `FLRL_OP_BL_LOCK, `FLRL_OP_BL_LOCK_W: begin
               blk_open_d[cmd_blk] = 1'b0; // RULE9
            end
            `FLRL_OP_BL_UNL, `FLRL_OP_BL_UNL_W: begin
               blk_open_d[cmd_blk] = 1'b1; // RULE10
            end
            `FLRL_OP_GBL: begin
               blk_open_d = {NUM_BLOCKS{1'b0}}; // RULE9
            end
            `FLRL_OP_GLOBAL_BLOCK_UNLOCK_CMD: begin
               blk_open_d = {NUM_BLOCKS{1'b1}}; // RULE10
            end
            `FLRL_OP_BL_RD, `FLRL_OP_BL_RD_W: begin
               rsp_valid_d = 1'b1;
               rsp_data_d  = {24'h000000,
                              blk_open_q[cmd_blk] ? `FLRL_BL_OPEN : `FLRL_BL_PROT}; // RULE11 RULE7
            end
            `FLRL_OP_SPG, `FLRL_OP_SPG_W: begin
               if (pg_write_ok) begin
                  ptr_d = ptr_wval; // RULE12
               end else begin
                  refused_d = 1'b1; // RULE2
               end
            end
            `FLRL_OP_WR_ANY: begin
               if ((cmd_addr == `FLRL_RA_POINTER) & pg_write_ok) begin
                  ptr_d = ptr_wval; // RULE12
               end else begin
                  // status is read-only, other targets belong elsewhere
                  refused_d = 1'b1; // RULE19 RULE2
               end
            end
            `FLRL_OP_RD_ANY: begin
               rsp_valid_d = 1'b1;
               if (cmd_addr == `FLRL_RA_LOCK_STATUS) begin
                  rsp_data_d = {24'h000000, lock_status_reg}; // RULE1
               end else if (cmd_addr == `FLRL_RA_POINTER) begin
                  rsp_data_d = pointer_guard_reg;
               end else begin
                  rsp_data_d = 32'h00000000;
               end
            end
            default: begin
               rsp_valid_d = 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         init_q <= 2'h0;
      end else if (!ready) begin
         init_q <= init_q + 2'h1;
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         blk_open_q     <= {NUM_BLOCKS{1'b0}};
         nv_config_lock <= 1'b0;
         rsp_valid      <= 1'b0;
         rsp_data       <= 32'h00000000;
         cmd_refused    <= 1'b0;
      end else begin
         blk_open_q     <= blk_open_d;
         nv_config_lock <= nv_config_lock_d;
         rsp_valid      <= rsp_valid_d;
         rsp_data       <= rsp_data_d;
         cmd_refused    <= refused_d;
      end
   end

   // non-volatile: soft reset leaves it alone, power-up shows the erased value
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pointer_guard_reg <= `FLRL_PG_RESET; // RULE17
      end else begin
         pointer_guard_reg <= ptr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // program and erase gate

   localparam SEC_W = `FLRL_PG_ADDR_HI - `FLRL_PG_ADDR_LO + 1;

   wire [SEC_W-1:0] pe_sec  = pe_addr[`FLRL_PG_ADDR_HI:`FLRL_PG_ADDR_LO];
   wire [SEC_W-1:0] ptr_sec = pointer_guard_reg[`FLRL_PG_ADDR_HI:`FLRL_PG_ADDR_LO];

   wire pg_active = ~pointer_guard_reg[`FLRL_PG_EN_BIT]; // RULE15
   wire pg_all    = pointer_guard_reg[`FLRL_PG_ALL_BIT]; // RULE14
   wire pg_bottom = pointer_guard_reg[`FLRL_PG_DIR_BIT]; // RULE16

   // region is inclusive of the pointed sector
   wire pg_in     = pg_all | (pg_bottom ? (pe_sec <= ptr_sec) : (pe_sec >= ptr_sec)); // RULE16
   wire pe_locked = ~blk_open_q[pe_blk] | (pg_active & pg_in); // RULE20

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pe_grant  <= 1'b0;
         pe_reject <= 1'b0;
      end else begin
         pe_grant  <= pe_req & ready & ~pe_locked;
         pe_reject <= pe_req & (~ready | pe_locked); // RULE20
      end
   end

endmodule

// ---- sim/flrl_lock_regs_properties.sv ----
// port assertions for the lock register block
`timescale 1ns/1ps
module flrl_chk (
   // clock and reset
   input wire        clk,
   input wire        arst_n,
   // requests
   input wire        cmd_valid,
   input wire [7:0]  cmd_opcode,
   input wire [31:0] cmd_addr,
   input wire [31:0] cmd_wdata,
   input wire        write_enable_latch,
   input wire        soft_reset,
   input wire        pe_req,
   // answers
   input wire        rsp_valid,
   input wire [31:0] rsp_data,
   input wire        cmd_refused,
   input wire        nv_config_lock,
   input wire [31:0] pointer_guard_reg,
   input wire        pe_grant,
   input wire        pe_reject
);
   reg  [1:0] up_q;
   wire       go;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         up_q <= 2'h0;
      else if (up_q != 2'h3)
         up_q <= up_q + 2'h1;
   end
   // commands before the start-up load, or beside a soft reset, are dropped
   assign go = cmd_valid & ~soft_reset & (up_q == 2'h3);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////
   property p_ls_rd;
      go && cmd_opcode == 8'hA7 |=> rsp_valid && rsp_data[31:7] == 25'h0
         && rsp_data[5:1] == 5'h00 && rsp_data[0] == nv_config_lock;
   endproperty
   property p_latch;
      go && cmd_opcode == 8'hA6 |=> nv_config_lock;
   endproperty
   property p_refuse;
      go && cmd_opcode == 8'hFB && !nv_config_lock |=> cmd_refused && $stable(pointer_guard_reg);
   endproperty
   property p_ls_wr;
      go && cmd_opcode == 8'h71 && cmd_addr == 32'h30 |=> cmd_refused && $stable(nv_config_lock);
   endproperty
   property p_pg_rst;
      $rose(arst_n) |-> pointer_guard_reg == 32'hFFFFFFFF;
   endproperty
   property p_bl_rd;
      go && (cmd_opcode == 8'h3D || cmd_opcode == 8'hE0) |=> rsp_valid
         && (rsp_data == 32'h0 || rsp_data == 32'hFF);
   endproperty
   property p_pe;
      pe_req |=> pe_grant != pe_reject;
   endproperty
   property p_pg_wr;
      go && cmd_opcode == 8'hFB && nv_config_lock && write_enable_latch
         |=> !cmd_refused && pointer_guard_reg == $past(cmd_wdata);
   endproperty
   a_ls_rd: assert property (p_ls_rd) else $error("status read wrong");
   a_latch: assert property (p_latch) else $error("latch failed");
   a_refuse: assert property (p_refuse) else $error("guard not refused");
   a_ls_wr: assert property (p_ls_wr) else $error("status written");
   a_pg_rst: assert property (p_pg_rst) else $error("pointer default");
   a_bl_rd: assert property (p_bl_rd) else $error("block read wrong");
   a_pe: assert property (p_pe) else $error("pe answer wrong");
   a_pg_wr: assert property (p_pg_wr) else $error("pointer write");
   cover property (go && cmd_opcode == 8'hA6);
   cover property (pe_reject);
   cover property (cmd_refused);
endmodule
bind flrl_lock_regs flrl_chk flrl_chk_inst (.clk(clk), .arst_n(arst_n),
   .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr),
   .cmd_wdata(cmd_wdata), .write_enable_latch(write_enable_latch),
   .soft_reset(soft_reset), .pe_req(pe_req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
   .cmd_refused(cmd_refused), .nv_config_lock(nv_config_lock),
   .pointer_guard_reg(pointer_guard_reg), .pe_grant(pe_grant), .pe_reject(pe_reject));

// ---- sim/flrl_host.sv ----
// host side command source for the lock register block
`timescale 1ns/1ps
module flrl_host (
   // clock
   input  wire        clk,
   // command out
   output reg         cmd_valid = 1'b0,
   output reg  [7:0]  cmd_opcode = 8'h00,
   output reg  [31:0] cmd_addr = 32'h0,
   output reg  [31:0] cmd_wdata = 32'h0,
   // answer in
   input  wire        rsp_valid,
   input  wire [31:0] rsp_data
);
   ////////////////////////////////////////
   // lines are inverted once released so stale values never look valid
   task xfer(input [7:0] o, input [31:0] a, input [31:0] d, output [31:0] r);
      begin
         @(posedge clk);
         #1 cmd_valid = 1'b1;
         cmd_opcode = o;
         cmd_addr = a;
         cmd_wdata = d;
         @(posedge clk);
         #1 cmd_valid = 1'b0;
         cmd_opcode = ~o;
         cmd_addr = ~a;
         cmd_wdata = ~d;
         r = rsp_valid ? rsp_data : 32'hBAD0BAD0;
      end
   endtask
endmodule

// ---- sim/tb.sv ----
// testbench for the lock register block
`timescale 1ns/1ps
module tb;
   reg         clk = 1'b0;
   reg         arst_n = 1'b0;
   reg         wel = 1'b1;
   reg         srst = 1'b0;
   reg         r3pw = 1'b1;
   reg         pe_req = 1'b0;
   reg         pwd_otp = 1'b0;
   reg         perm_otp = 1'b1;
   reg         boot_otp = 1'b1;
   reg  [31:0] pe_addr = 32'h0;
   reg  [31:0] v;
   reg  [31:0] tbl [0:5];
   wire        cv, rv, refd, nvl, grant, rej;
   wire [7:0]  op;
   wire [31:0] ca, cd, rd, pg;
   integer     i;
   integer     error_cnt = 0;
   integer     check_count = 0;
   always #2.5 clk = ~clk;
   flrl_host flrl_host_inst (.clk(clk), .cmd_valid(cv), .cmd_opcode(op), .cmd_addr(ca),
      .cmd_wdata(cd), .rsp_valid(rv), .rsp_data(rd));
   flrl_lock_regs flrl_lock_regs_inst (.clk(clk), .arst_n(arst_n), .cmd_valid(cv),
      .cmd_opcode(op), .cmd_addr(ca), .cmd_wdata(cd), .write_enable_latch(wel),
      .soft_reset(srst), .region3_read_password(r3pw), .guard_mode_otp_pwd(pwd_otp),
      .guard_mode_otp_perm(perm_otp), .block_lock_boot_default(boot_otp), .pe_req(pe_req),
      .pe_addr(pe_addr), .rsp_valid(rv), .rsp_data(rd), .cmd_refused(refd),
      .nv_config_lock(nvl), .pointer_guard_reg(pg), .pe_grant(grant), .pe_reject(rej));
   ////////////////////////////////////////
   task chk(input string nm, input [31:0] exp, input [31:0] seen);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task cmd(input [7:0] o, input [31:0] a, input [31:0] d);
      flrl_host_inst.xfer(o, a, d, v);
   endtask
   task pe(input [31:0] a, input g);
      begin
         @(posedge clk);
         #1 pe_req = 1'b1;
         pe_addr = a;
         @(posedge clk);
         #1 pe_req = 1'b0;
         pe_addr = ~a;
         chk("pe_grant", {31'h0, g}, {31'h0, grant});
         chk("pe_reject", {31'h0, !g}, {31'h0, rej});
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d errors %0d", check_count, error_cnt);
         if (error_cnt == 0 && check_count > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   initial begin
      #5000;
      error_cnt = error_cnt + 1;
      finish_test;
   end
   ////////////////////////////////////////
   initial begin
      tbl[0] = 32'h363D0100;
      tbl[1] = 32'hE1E00200;
      tbl[2] = 32'h393D01FF;
      tbl[3] = 32'hE2E002FF;
      tbl[4] = 32'h7E3D0300;
      tbl[5] = 32'h98E003FF;
      repeat (6) @(posedge clk);
      #1 arst_n = 1'b1;
      repeat (6) @(posedge clk);
      chk("pointer", 32'hFFFFFFFF, pg);
      chk("nv_config_lock", 32'h0, {31'h0, nvl});
      cmd(8'hA7, 32'h0, 32'h0);
      chk("status", 32'h40, v);
      cmd(8'h65, 32'h30, 32'h0);
      chk("status_any", 32'h40, v);
      cmd(8'h3D, 32'h10000, 32'h0);
      chk("boot_lock", 32'h0, v);
      pe(32'h10000, 1'b0);
      cmd(8'hFB, 32'h0, 32'h0);
      chk("refused", 32'h1, {31'h0, refd});
      chk("pointer_kept", 32'hFFFFFFFF, pg);
      cmd(8'h71, 32'h30, 32'h1);
      chk("wr_status", 32'h1, {31'h0, refd});
      cmd(8'hA6, 32'h0, 32'h0);
      chk("latch", 32'h1, {31'h0, nvl});
      r3pw = 1'b0;
      repeat (3) @(posedge clk);
      cmd(8'hA7, 32'h0, 32'h0);
      chk("status2", 32'h01, v);
      $display("test status done");
      cmd(8'h98, 32'h0, 32'h0);
      cmd(8'hFB, 32'h0, 32'hFFFF01FF);
      cmd(8'h65, 32'h40, 32'h0);
      chk("pointer_rd", 32'hFFFF01FF, v);
      pe(32'h0, 1'b1);
      pe(32'h1FF0000, 1'b0);
      cmd(8'hE3, 32'h0, 32'hFE0103FF);
      pe(32'h0, 1'b0);
      pe(32'h20000, 1'b1);
      cmd(8'h71, 32'h40, 32'hFFFFFBFF);
      pe(32'h20000, 1'b0);
      cmd(8'hFB, 32'h0, 32'hFFFFFFFF);
      pe(32'h20000, 1'b1);
      wel = 1'b0;
      cmd(8'hFB, 32'h0, 32'h0);
      chk("wel_refused", 32'h1, {31'h0, refd});
      $display("test pointer done");
      for (i = 0; i < 6; i = i + 1) begin
         cmd(tbl[i][31:24], {8'h0, tbl[i][15:8], 16'h0}, 32'h0);
         cmd(tbl[i][23:16], {8'h0, tbl[i][15:8], 16'h0}, 32'h0);
         chk("block_lock", {24'h0, tbl[i][7:0]}, v);
      end
      // a pointer value unlike the erased one shows that soft reset keeps it
      wel = 1'b1;
      cmd(8'hFB, 32'h0, 32'hFFFF03FF);
      chk("pointer_set", 32'hFFFF03FF, pg);
      @(posedge clk);
      #1 srst = 1'b1;
      @(posedge clk);
      #1 srst = 1'b0;
      cmd(8'h3D, 32'h10000, 32'h0);
      chk("reset_lock", 32'h0, v);
      chk("pointer_soft", 32'hFFFF03FF, pg);
      chk("nv_config_lock_soft", 32'h0, {31'h0, nvl});
      $display("test blocks done");
      // other mode bits: blocks come up open, config lock comes up set
      boot_otp = 1'b0;
      pwd_otp = 1'b1;
      repeat (3) @(posedge clk);
      #1 srst = 1'b1;
      @(posedge clk);
      #1 srst = 1'b0;
      cmd(8'hE0, 32'h00020000, 32'h0);
      chk("boot_open", 32'hFF, v);
      chk("nv_config_lock_boot", 32'h1, {31'h0, nvl});
      cmd(8'hA7, 32'h0, 32'h0);
      chk("status3", 32'h01, v);
      $display("test boot done");
      finish_test;
   end
endmodule
